// ---- test_virtual_phy_status_id_regs.sv ----
// test_virtual_phy_status_id_regs: self-checking bench for the status and identifier bank
// assumes vpsr_pkg, vpsr_regs and vpsr_mii_master are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_virtual_phy_status_id_regs;
    localparam int AN = 3;
    // abilities 14..11, an ability 3, link 2, extended 0; an-complete is bit 5
    localparam logic [15:0] ST_IDLE = 16'h780D;
    localparam logic [15:0] ST_DONE = 16'h782D;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    vpsr_pkg::vpsr_req_t host_req = '0;
    logic [31:0] host_rdata;
    logic host_rvalid;
    logic mii_rd;
    logic mii_wr;
    logic [4:0] mii_index;
    logic [15:0] mii_wdata;
    logic [15:0] mii_rdata;
    logic mii_rvalid;
    logic mii_index_valid;
    logic an_complete;
    int bad_count = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] lfsr = 32'hC9A2;
    logic [15:0] oui = 16'h0000;
    logic [31:0] hq[$];
    logic [15:0] mq[$];
    initial forever #25 clk = ~clk;
    vpsr_regs #(.AN_CYCLES(AN)) vpsr_regs_i (.clk, .sys_rst, .host_req, .host_rdata, .host_rvalid, .mii_rd,
        .mii_wr, .mii_index, .mii_wdata, .mii_rdata, .mii_rvalid, .mii_index_valid, .an_complete);
    vpsr_mii_master vpsr_mii_master_i (.clk, .mii_rd, .mii_wr, .mii_index, .mii_wdata);
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic host_op(input logic rd, input logic wr, input logic [11:0] a, input logic [31:0] d,
        input logic [31:0] exp);
        @(posedge clk);
        host_req <= '{rd: rd, wr: wr, addr: a, wdata: d};
        if (rd) hq.push_back(exp);
        @(posedge clk);
        host_req <= '0;
    endtask : host_op
    task automatic mii_op(input logic rd, input logic wr, input logic [4:0] i, input logic [15:0] d,
        input logic [15:0] exp);
        if (rd) mq.push_back(exp);
        vpsr_mii_master_i.xfer(rd, wr, i, d);
    endtask : mii_op
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc > 3000) begin
            bad_count++;
            conclude();
        end
        if (host_rvalid === 1'b1) check("host_rdata", host_rdata, hq.pop_front());
        if (mii_rvalid === 1'b1) check("mii_rdata", {16'h0, mii_rdata}, {16'h0, mq.pop_front()});
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        #1 check("an_complete", an_complete, 0);
        host_op(1, 0, vpsr_pkg::ADDR_CAPABILITY_STATUS, 0, {16'h0, ST_IDLE});
        repeat (AN + 3) @(posedge clk);
        check("an_complete", an_complete, 1);
        host_op(1, 0, vpsr_pkg::ADDR_CAPABILITY_STATUS, 0, {16'h0, ST_DONE});
        $display("test status done");
        host_op(0, 1, vpsr_pkg::ADDR_CAPABILITY_STATUS, 32'hFFFF_FFFF, 0);
        mii_op(0, 1, 5'h01, 16'h0000, 0);
        host_op(1, 0, vpsr_pkg::ADDR_CAPABILITY_STATUS, 0, {16'h0, ST_DONE});
        for (int k = 0; k < 4; k++) begin
            lfsr = next_rand(lfsr);
            oui = (k == 3) ? 16'h0000 : lfsr[15:0];
            host_op(0, 1, vpsr_pkg::ADDR_OUI_UPPER, {lfsr[31:16], oui}, 0);
            host_op(1, 0, vpsr_pkg::ADDR_OUI_UPPER, 0, {16'h0, oui});
            mii_op(1, 0, 5'h02, 0, oui);
        end
        $display("test oui upper done");
        for (int i = 0; i < 8; i++) begin
            mii_op(1, 0, i[4:0], 0, (i == 1) ? ST_DONE : (i == 2) ? oui : 16'h0000);
            #1 check("mii_index_valid", mii_index_valid, i <= 6);
        end
        mii_op(0, 1, 5'h03, 16'hA5C3, 0);
        host_op(1, 0, vpsr_pkg::ADDR_OUI_LOWER, 0, 32'h0000_A5C3);
        host_op(1, 0, 12'h1D8, 0, 0);
        $display("test mii index done");
        host_op(0, 1, vpsr_pkg::ADDR_OUI_UPPER, 32'h0000_5A5A, 0);
        host_op(0, 1, vpsr_pkg::ADDR_BASIC_CTRL, 32'h0000_8000, 0);
        repeat (2) @(posedge clk);
        #1 check("an_complete", an_complete, 0);
        host_op(1, 0, vpsr_pkg::ADDR_OUI_UPPER, 0, 0);
        mii_op(1, 0, 5'h03, 0, 16'h0000);
        repeat (AN + 4) @(posedge clk);
        check("an_complete", an_complete, 1);
        $display("test soft reset done");
        lfsr = next_rand(lfsr);
        mii_op(0, 1, 5'h02, lfsr[31:16], 0);
        host_op(0, 1, vpsr_pkg::ADDR_OUI_LOWER, lfsr, 0);
        host_op(1, 0, vpsr_pkg::ADDR_OUI_UPPER, 0, {16'h0, lfsr[31:16]});
        mii_op(1, 0, 5'h03, 0, lfsr[15:0]);
        mii_op(0, 1, 5'h00, 16'h8000, 0);
        repeat (2) @(posedge clk);
        #1 check("an_complete", an_complete, 0);
        mii_op(1, 0, 5'h02, 0, 16'h0000);
        host_op(1, 0, vpsr_pkg::ADDR_OUI_LOWER, 0, 0);
        repeat (AN + 4) @(posedge clk);
        check("an_complete", an_complete, 1);
        $display("test mii reset done");
        repeat (3) @(posedge clk);
        check("host_q", hq.size(), 0);
        check("mii_q", mq.size(), 0);
        conclude();
    end
endmodule : test_virtual_phy_status_id_regs
`default_nettype wire

// ---- vpsr_an_timer.sv ----
// vpsr_an_timer: emulated auto-negotiation run, raises done a fixed time after restart
// assumes restart is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module vpsr_an_timer #(
    parameter int CYCLES = vpsr_pkg::AN_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic restart,
    output logic done
);
    typedef struct packed {
        logic [15:0] cnt;
        logic done;
    } vpsr_an_state_t;
    vpsr_an_state_t st_q, st_d;

    always_comb begin
        st_d = st_q;
        if (restart) begin // R6 R13
            st_d.cnt = 16'h0000;
            st_d.done = 1'b0;
        end else if (!st_q.done) begin
            if (st_q.cnt == 16'(CYCLES - 1)) begin
                st_d.done = 1'b1; // R6
            end else begin
                st_d.cnt = st_q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done = st_q.done;

    AST_AN_DONE_LATE: assert property (@(posedge clk) disable iff (sys_rst) // R6
        restart |=> !done [*2])
        else $error("done rose too soon after restart");
    AST_AN_HOLD: assert property (@(posedge clk) disable iff (sys_rst) // R6
        done && !restart |=> done)
        else $error("done fell without a restart");
endmodule : vpsr_an_timer
`default_nettype wire

// ---- vpsr_mii_master.sv ----
// vpsr_mii_master: management master model issuing one-cycle register transfers
// assumes one bench process calls xfer at a time, all on clk
`timescale 1ns/1ps
`default_nettype none
module vpsr_mii_master (
    input wire logic clk,
    output logic mii_rd,
    output logic mii_wr,
    output logic [4:0] mii_index,
    output logic [15:0] mii_wdata
);
    initial begin
        mii_rd = 1'b0;
        mii_wr = 1'b0;
        mii_index = 5'h1F;
        mii_wdata = 16'hFFFF;
    end
    task automatic xfer(input logic rd, input logic wr, input logic [4:0] idx, input logic [15:0] wd);
        @(posedge clk);
        mii_rd <= rd;
        mii_wr <= wr;
        mii_index <= idx;
        mii_wdata <= wd;
        @(posedge clk);
        mii_rd <= 1'b0;
        mii_wr <= 1'b0;
        // released lines show the inverse so a stale value cannot pass
        mii_index <= ~idx;
        mii_wdata <= ~wd;
    endtask : xfer
endmodule : vpsr_mii_master
`default_nettype wire

// ---- vpsr_pkg.sv ----
// vpsr_pkg: constants and carrier types for the emulated phy status/id register bank
// assumes a single 20 MHz clock domain shared by all users
package vpsr_pkg;
    localparam logic [11:0] ADDR_BASIC_CTRL = 12'h1C0;
    localparam logic [11:0] ADDR_CAPABILITY_STATUS = 12'h1C4;
    localparam logic [11:0] ADDR_OUI_UPPER = 12'h1C8;
    localparam logic [11:0] ADDR_OUI_LOWER = 12'h1CC;
    localparam logic [4:0] MII_IDX_CTRL = 5'h00;
    localparam logic [4:0] MII_IDX_STATUS = 5'h01;
    localparam logic [4:0] MII_IDX_OUI_UPPER = 5'h02;
    localparam logic [4:0] MII_IDX_OUI_LOWER = 5'h03;
    localparam logic [4:0] MII_IDX_LAST = 5'h06;
    localparam int CTRL_SOFT_RESET_BIT = 15;
    localparam int STATUS_AN_DONE_BIT = 5;
    localparam logic [15:0] STATUS_FIXED = 16'h780D;
    localparam logic [15:0] OUI_UPPER_RESET = 16'h0000;
    localparam logic [15:0] OUI_LOWER_RESET = 16'h0000;
    localparam int AN_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int AN_CYCLES = (AN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [31:0] wdata;
    } vpsr_req_t;

    typedef struct packed {
        logic [5:0] oui_low;
        logic [5:0] model;
        logic [3:0] revision;
    } vpsr_oui_lower_t;
endpackage : vpsr_pkg

// ---- vpsr_regs.sv ----
// vpsr_regs: emulated phy basic status and identifier registers, memory mapped and mii indexed
// assumes host requests and mii index reads come from logic on clk; one access per cycle
// Function
// [R1] upper sixteen bits read zero; mii sixteen
// [R2] bits 15, 10, 9 read zero
// [R3] bits 14..11 read one
// [R4] bit 8 reads zero, no extended status
// [R5] preamble suppression bit 6 reads zero
// [R6] an-complete clears on reset, sets later
// [R7] fault, jabber zero; link always up
// [R8] auto-negotiation ability bit 3 one
// [R9] extended capability one; indices 0-6 exist
// [R10] status at 1C4h and index 1, read-only
// [R11] oui upper at 1C8h, writable, resets zero
// [R12] all-zero identifier stored unchanged
// [R13] soft reset restores defaults, clears an-complete
// [R14] lower id: oui 15:10, model 9:4, rev 3:0
// [R15] writes to read-only bits ignored
`timescale 1ns/1ps
`default_nettype none
module vpsr_regs #(
    parameter int AN_CYCLES = vpsr_pkg::AN_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire vpsr_pkg::vpsr_req_t host_req,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    input wire logic mii_rd,
    input wire logic mii_wr,
    input wire logic [4:0] mii_index,
    input wire logic [15:0] mii_wdata,
    output logic [15:0] mii_rdata,
    output logic mii_rvalid,
    output logic mii_index_valid,
    output logic an_complete
);
    typedef struct packed {
        logic [15:0] oui_upper;
        vpsr_pkg::vpsr_oui_lower_t oui_lower;
        logic soft_rst;
        logic [31:0] host_rdata;
        logic host_rvalid;
        logic [15:0] mii_rdata;
        logic mii_rvalid;
        logic mii_index_valid;
        logic an_complete;
    } vpsr_regs_state_t;
    vpsr_regs_state_t st_q, st_d;

    logic an_done;
    logic [15:0] status_word;
    logic host_wr_oui_up, host_wr_oui_lo, host_wr_ctrl;
    logic mii_wr_oui_up, mii_wr_oui_lo, mii_wr_ctrl;

    vpsr_an_timer #(
        .CYCLES(AN_CYCLES)
    ) u_an (
        .clk(clk),
        .sys_rst(sys_rst),
        .restart(st_q.soft_rst),
        .done(an_done)
    );

    always_comb begin
        status_word = vpsr_pkg::STATUS_FIXED; // R2 R3 R4 R5 R7 R8 R9
        status_word[vpsr_pkg::STATUS_AN_DONE_BIT] = an_done; // R6
    end

    always_comb begin
        host_wr_ctrl = 1'b0;
        host_wr_oui_up = 1'b0;
        host_wr_oui_lo = 1'b0;
        if (host_req.wr && host_req.addr == vpsr_pkg::ADDR_BASIC_CTRL) begin
            host_wr_ctrl = 1'b1;
        end else if (host_req.wr && host_req.addr == vpsr_pkg::ADDR_OUI_UPPER) begin
            host_wr_oui_up = 1'b1;
        end else if (host_req.wr && host_req.addr == vpsr_pkg::ADDR_OUI_LOWER) begin
            host_wr_oui_lo = 1'b1;
        end
        mii_wr_ctrl = mii_wr && mii_index == vpsr_pkg::MII_IDX_CTRL;
        mii_wr_oui_up = mii_wr && mii_index == vpsr_pkg::MII_IDX_OUI_UPPER;
        mii_wr_oui_lo = mii_wr && mii_index == vpsr_pkg::MII_IDX_OUI_LOWER;
    end

    always_comb begin
        st_d = st_q;
        st_d.soft_rst = 1'b0;
        // host wins if both ports write the same identifier register in one cycle
        if (mii_wr_oui_up) begin
            st_d.oui_upper = mii_wdata; // R11 R12
        end
        if (host_wr_oui_up) begin
            st_d.oui_upper = host_req.wdata[15:0]; // R11 R12 R1
        end
        if (mii_wr_oui_lo) begin
            st_d.oui_lower = mii_wdata; // R14
        end
        if (host_wr_oui_lo) begin
            st_d.oui_lower = host_req.wdata[15:0]; // R14
        end
        // status register writes are never decoded, so they cannot disturb state // R15
        if ((host_wr_ctrl && host_req.wdata[vpsr_pkg::CTRL_SOFT_RESET_BIT]) ||
            (mii_wr_ctrl && mii_wdata[vpsr_pkg::CTRL_SOFT_RESET_BIT])) begin
            st_d.soft_rst = 1'b1; // R13
            st_d.oui_upper = vpsr_pkg::OUI_UPPER_RESET; // R13
            st_d.oui_lower = vpsr_pkg::OUI_LOWER_RESET; // R13
        end
        st_d.host_rvalid = host_req.rd;
        st_d.host_rdata = 32'h0000_0000;
        if (host_req.rd) begin
            if (host_req.addr == vpsr_pkg::ADDR_CAPABILITY_STATUS) begin
                st_d.host_rdata = {16'h0000, status_word}; // R10 R1
            end else if (host_req.addr == vpsr_pkg::ADDR_OUI_UPPER) begin
                st_d.host_rdata = {16'h0000, st_q.oui_upper}; // R1 R11
            end else if (host_req.addr == vpsr_pkg::ADDR_OUI_LOWER) begin
                st_d.host_rdata = {16'h0000, st_q.oui_lower}; // R1 R14
            end
        end
        st_d.mii_rvalid = mii_rd;
        st_d.mii_rdata = 16'h0000;
        st_d.mii_index_valid = mii_index <= vpsr_pkg::MII_IDX_LAST; // R9
        if (mii_rd) begin
            if (mii_index == vpsr_pkg::MII_IDX_STATUS) begin
                st_d.mii_rdata = status_word; // R10
            end else if (mii_index == vpsr_pkg::MII_IDX_OUI_UPPER) begin
                st_d.mii_rdata = st_q.oui_upper;
            end else if (mii_index == vpsr_pkg::MII_IDX_OUI_LOWER) begin
                st_d.mii_rdata = st_q.oui_lower;
            end
        end
        st_d.an_complete = an_done;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign host_rdata = st_q.host_rdata;
    assign host_rvalid = st_q.host_rvalid;
    assign mii_rdata = st_q.mii_rdata;
    assign mii_rvalid = st_q.mii_rvalid;
    assign mii_index_valid = st_q.mii_index_valid;
    assign an_complete = st_q.an_complete;

    sequence s_status_read;
        host_req.rd && host_req.addr == vpsr_pkg::ADDR_CAPABILITY_STATUS;
    endsequence

    sequence s_mii_status_read;
        mii_rd && mii_index == vpsr_pkg::MII_IDX_STATUS;
    endsequence

    // a soft reset may come from either port; an_complete lags the timer by one flop
    sequence s_soft_reset_req;
        (host_wr_ctrl && host_req.wdata[vpsr_pkg::CTRL_SOFT_RESET_BIT]) ||
            (mii_wr_ctrl && mii_wdata[vpsr_pkg::CTRL_SOFT_RESET_BIT]);
    endsequence

    sequence s_host_unmapped_read;
        host_req.rd && host_req.addr != vpsr_pkg::ADDR_CAPABILITY_STATUS &&
            host_req.addr != vpsr_pkg::ADDR_OUI_UPPER && host_req.addr != vpsr_pkg::ADDR_OUI_LOWER;
    endsequence

    sequence s_mii_unmapped_read;
        mii_rd && mii_index != vpsr_pkg::MII_IDX_STATUS &&
            mii_index != vpsr_pkg::MII_IDX_OUI_UPPER && mii_index != vpsr_pkg::MII_IDX_OUI_LOWER;
    endsequence

    AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // R1
        host_rvalid |-> host_rdata[31:16] == 16'h0000)
        else $error("reserved bits nonzero");
    AST_HOST_ANSWER: assert property (@(posedge clk) disable iff (sys_rst) // R10
        host_req.rd |=> host_rvalid)
        else $error("host read not answered next cycle");
    AST_HOST_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // R1
        !host_req.rd |=> !host_rvalid && host_rdata == 32'h0000_0000)
        else $error("host read data not cleared");
    AST_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // R1
        s_host_unmapped_read |=> host_rdata == 32'h0000_0000)
        else $error("unmapped host read not zero");
    AST_T4_T2_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // R2
        s_status_read |=> host_rdata[15] == 1'b0 && host_rdata[10:9] == 2'b00)
        else $error("unable bits set");
    AST_MODES_ONE: assert property (@(posedge clk) disable iff (sys_rst) // R3
        s_status_read |=> host_rdata[14:11] == 4'hF)
        else $error("supported modes not one");
    AST_EXT_STATUS_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // R4 R5
        s_status_read |=> !host_rdata[8] && !host_rdata[6])
        else $error("bit 8 or 6 set");
    AST_ABILITY_ONE: assert property (@(posedge clk) disable iff (sys_rst) // R8 R9
        s_status_read |=> host_rdata[3] == 1'b1 && host_rdata[0] == 1'b1)
        else $error("ability bits not one");
    AST_AN_MIRROR: assert property (@(posedge clk) disable iff (sys_rst) // R6
        s_status_read |=> host_rdata[5] == $past(an_done))
        else $error("an-complete wrong");
    AST_LINK_FAULT: assert property (@(posedge clk) disable iff (sys_rst) // R7
        s_mii_status_read |=> mii_rdata[4:0] == 5'h0D)
        else $error("link bits wrong");
    AST_MII_STATUS_FIXED: assert property (@(posedge clk) disable iff (sys_rst) // R10
        s_mii_status_read |=> {mii_rdata[15:6], mii_rdata[4:0]} ==
            {vpsr_pkg::STATUS_FIXED[15:6], vpsr_pkg::STATUS_FIXED[4:0]})
        else $error("serial status read wrong");
    AST_MII_ANSWER: assert property (@(posedge clk) disable iff (sys_rst) // R1
        mii_rd |=> mii_rvalid)
        else $error("serial read not answered next cycle");
    AST_MII_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // R1
        !mii_rd |=> !mii_rvalid && mii_rdata == 16'h0000)
        else $error("serial read data not cleared");
    AST_MII_UNMAPPED_ZERO: assert property (@(posedge clk) disable iff (sys_rst) // R9
        s_mii_unmapped_read |=> mii_rdata == 16'h0000)
        else $error("unmapped serial read not zero");
    AST_MII_INDEX_OK: assert property (@(posedge clk) disable iff (sys_rst) // R9
        mii_index <= vpsr_pkg::MII_IDX_LAST |=> mii_index_valid)
        else $error("implemented index not flagged");
    AST_MII_INDEX_RANGE: assert property (@(posedge clk) disable iff (sys_rst) // R9
        mii_index > vpsr_pkg::MII_IDX_LAST |=> !mii_index_valid)
        else $error("missing index flagged valid");
    AST_SOFT_RESET: assert property (@(posedge clk) disable iff (sys_rst) // R13
        s_soft_reset_req |=> ##2 !an_complete)
        else $error("soft reset left an-complete set");
    AST_SOFT_RESET_REGS: assert property (@(posedge clk) disable iff (sys_rst) // R13
        s_soft_reset_req |=> st_q.oui_upper == vpsr_pkg::OUI_UPPER_RESET &&
            st_q.oui_lower == vpsr_pkg::OUI_LOWER_RESET)
        else $error("soft reset left identifier set");
    AST_OUI_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // R11 R12
        host_wr_oui_up && !mii_wr_ctrl |=> st_q.oui_upper == $past(host_req.wdata[15:0]))
        else $error("oui not stored");
    AST_OUI_LOWER_WRITE: assert property (@(posedge clk) disable iff (sys_rst) // R14
        mii_wr_oui_lo && !host_req.wr |=> st_q.oui_lower == $past(mii_wdata))
        else $error("lower id not stored");
    AST_RO_IGNORED: assert property (@(posedge clk) disable iff (sys_rst) // R15
        host_req.wr && host_req.addr == vpsr_pkg::ADDR_CAPABILITY_STATUS && !mii_wr |=>
            $stable(st_q.oui_upper))
        else $error("status write had effect");
    AST_RO_MII: assert property (@(posedge clk) disable iff (sys_rst) // R15
        mii_wr && mii_index == vpsr_pkg::MII_IDX_STATUS && !host_req.wr |=>
            $stable(st_q.oui_upper) && $stable(st_q.oui_lower))
        else $error("serial status write had effect");
endmodule : vpsr_regs
`default_nettype wire
